// [design/virtual_io_and_comparators.sv]
// What this block does
// - a function request is the OR of physical input and virtual destination
// - eight virtual connections, destination and source both reset to off
// - everything re-evaluates once per 8 ms update tick only
// - each comparator output has a set delay and a reset delay
// - four analogue comparators, upper and lower level, hysteresis or window
// - hysteresis: above upper level sets true output, clears inverted
// - hysteresis: below lower level clears true output, sets inverted
// - hysteresis: crossing a level the other way changes nothing
// - hysteresis: lower level above upper level makes a latch
// - window: value inside the band gives true high, inverted low
// - window: value outside the band gives true low, inverted high
// - analogue source code 0 to 15, default current (code 4)
// - four digital comparators, each watching a selected internal signal
// - comparator outputs feed virtual sources and relays
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "vio_defines.svh"
module virtual_io_and_comparators
  import vio_pkg::*;
#(
  parameter int          NUM_VC      = 8,
  parameter int          NUM_ACMP    = 4,
  parameter int          NUM_DCMP    = 4,
  parameter int          VAL_W       = 16,
  parameter int          DLY_W       = 24,
  parameter int          NUM_FUNC    = 64,
  parameter int          NUM_DIG     = 116,
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  input  logic                   mclk,
  input  logic                   rst_n,
  input  logic                   hsel,
  input  logic [31:0]            haddr,
  input  logic [1:0]             htrans,
  input  logic                   hwrite,
  input  logic [2:0]             hsize,
  input  logic [31:0]            hwdata,
  input  logic                   hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  logic [15:0][VAL_W-1:0] analogValues,
  input  logic [NUM_DIG-1:0]     digSignals,
  input  logic [NUM_FUNC-1:0]    physFuncReq,
  output logic [NUM_FUNC-1:0]    funcReq,
  output cmpOut_type             cmpOut,
  output logic                   updateTick
);

  localparam int NSRC  = 12 + NUM_DIG;
  localparam int TCW   = $clog2(TICK_CYCLES + 1);

  localparam logic [7:0] VcOfs   = `VC_OFS;
  localparam logic [7:0] AcfgOfs = `ACFG_OFS;
  localparam logic [7:0] AupOfs  = `AUP_OFS;
  localparam logic [7:0] AloOfs  = `ALO_OFS;
  localparam logic [7:0] AsetOfs = `ASET_OFS;
  localparam logic [7:0] AresOfs = `ARES_OFS;
  localparam logic [7:0] DselOfs = `DSEL_OFS;
  localparam logic [7:0] DsetOfs = `DSET_OFS;
  localparam logic [7:0] DresOfs = `DRES_OFS;
  localparam logic [7:0] StatOfs = `STAT_OFS;

  // ----------------------------------------------------------------
  // update tick divider
  // ----------------------------------------------------------------
  logic [TCW-1:0] tickCnt_q;
  logic           tickEn;

  assign tickEn = (tickCnt_q == TCW'(TICK_CYCLES - 1));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= '0;
    end else if (tickEn) begin
      tickCnt_q <= '0;
    end else begin
      tickCnt_q <= tickCnt_q + TCW'(1);
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave: address phase capture
  // ----------------------------------------------------------------
  // zero wait states; read data is fetched in the address phase, so a
  // read directly behind a write to the same word sees the old value
  logic       accept;
  logic       wrPend_q;
  logic [7:0] wrAddr_q;
  logic [7:0] ra;
  logic [7:0] wa;

  assign accept = hsel && htrans[1] && hready;
  assign ra     = {haddr[7:2], 2'b00};
  assign wa     = wrAddr_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q  <= 1'b0;
      wrAddr_q  <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_q  <= accept && hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (accept) begin
        wrAddr_q <= ra;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic       wVc;
  logic       wAcfg;
  logic       wAup;
  logic       wAlo;
  logic       wAset;
  logic       wAres;
  logic       wDsel;
  logic       wDset;
  logic       wDres;
  logic [2:0] wIdx8;
  logic [1:0] wIdx4;

  assign wVc   = wrPend_q && wa[7:5] == VcOfs[7:5];
  assign wAcfg = wrPend_q && wa[7:4] == AcfgOfs[7:4];
  assign wAup  = wrPend_q && wa[7:4] == AupOfs[7:4];
  assign wAlo  = wrPend_q && wa[7:4] == AloOfs[7:4];
  assign wAset = wrPend_q && wa[7:4] == AsetOfs[7:4];
  assign wAres = wrPend_q && wa[7:4] == AresOfs[7:4];
  assign wDsel = wrPend_q && wa[7:4] == DselOfs[7:4];
  assign wDset = wrPend_q && wa[7:4] == DsetOfs[7:4];
  assign wDres = wrPend_q && wa[7:4] == DresOfs[7:4];
  assign wIdx8 = wa[4:2];
  assign wIdx4 = wa[3:2];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  vconn_type         vconn_q   [NUM_VC];
  acmpCfg_type       acmpCfg_q [NUM_ACMP];
  logic [VAL_W-1:0]  upper_q   [NUM_ACMP];
  logic [VAL_W-1:0]  lower_q   [NUM_ACMP];
  logic [DLY_W-1:0]  aSetDly_q [NUM_ACMP];
  logic [DLY_W-1:0]  aResDly_q [NUM_ACMP];
  logic [7:0]        dSel_q    [NUM_DCMP];
  logic [DLY_W-1:0]  dSetDly_q [NUM_DCMP];
  logic [DLY_W-1:0]  dResDly_q [NUM_DCMP];

  genvar gv;
  generate
    for (gv = 0; gv < NUM_VC; gv++) begin : g_vcreg
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          vconn_q[gv] <= '{src: `VC_OFF, dest: `VC_OFF};
        end else if (wVc && wIdx8 == 3'(gv)) begin
          vconn_q[gv].dest <= hwdata[`VC_DEST_LSB +: 8];
          vconn_q[gv].src  <= hwdata[`VC_SRC_LSB +: 8];
        end
      end
    end
    for (gv = 0; gv < NUM_ACMP; gv++) begin : g_areg
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          acmpCfg_q[gv] <= '{mode: HYSTERESIS, sel: `ACFG_SEL_RST};
          upper_q[gv]   <= `AUP_RST;
          lower_q[gv]   <= `ALO_RST;
          aSetDly_q[gv] <= `DLY_RST;
          aResDly_q[gv] <= `DLY_RST;
        end else begin
          if (wAcfg && wIdx4 == 2'(gv)) begin
            acmpCfg_q[gv].sel  <= hwdata[`ACFG_SEL_LSB +: 4];
            acmpCfg_q[gv].mode <= cmpMode_type'(hwdata[`ACFG_MODE_BIT]);
          end
          if (wAup && wIdx4 == 2'(gv)) begin
            upper_q[gv] <= hwdata[VAL_W-1:0];
          end
          if (wAlo && wIdx4 == 2'(gv)) begin
            lower_q[gv] <= hwdata[VAL_W-1:0];
          end
          if (wAset && wIdx4 == 2'(gv)) begin
            aSetDly_q[gv] <= hwdata[DLY_W-1:0];
          end
          if (wAres && wIdx4 == 2'(gv)) begin
            aResDly_q[gv] <= hwdata[DLY_W-1:0];
          end
        end
      end
    end
    for (gv = 0; gv < NUM_DCMP; gv++) begin : g_dreg
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          dSel_q[gv]    <= `DSEL_RST;
          dSetDly_q[gv] <= `DLY_RST;
          dResDly_q[gv] <= `DLY_RST;
        end else begin
          if (wDsel && wIdx4 == 2'(gv)) begin
            dSel_q[gv] <= hwdata[7:0];
          end
          if (wDset && wIdx4 == 2'(gv)) begin
            dSetDly_q[gv] <= hwdata[DLY_W-1:0];
          end
          if (wDres && wIdx4 == 2'(gv)) begin
            dResDly_q[gv] <= hwdata[DLY_W-1:0];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  logic [NUM_ACMP-1:0] aRaw;
  logic [NUM_ACMP-1:0] aDly;
  logic [NUM_DCMP-1:0] dRaw;
  logic [NUM_DCMP-1:0] dDly;
  logic [NSRC:0]       digPad;

  // code 0 of a digital comparator input reads as inactive
  assign digPad = {12'h000, digSignals, 1'b0};

  generate
    for (gv = 0; gv < NUM_ACMP; gv++) begin : g_acmp
      analog_cmp #(
        .VAL_W (VAL_W)
      ) u_cmp (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .tick   (tickEn),
        .value  (analogValues[acmpCfg_q[gv].sel]),
        .upper  (upper_q[gv]),
        .lower  (lower_q[gv]),
        .mode   (acmpCfg_q[gv].mode),
        .cmpRaw (aRaw[gv])
      );
      onoff_delay #(
        .DLY_W (DLY_W)
      ) u_dly (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .tick   (tickEn),
        .rawIn  (aRaw[gv]),
        .setDly (aSetDly_q[gv]),
        .resDly (aResDly_q[gv]),
        .dlyOut (aDly[gv])
      );
    end
    for (gv = 0; gv < NUM_DCMP; gv++) begin : g_dcmp
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          dRaw[gv] <= 1'b0;
        end else if (tickEn) begin
          dRaw[gv] <= (dSel_q[gv] <= 8'(NUM_DIG)) && digPad[dSel_q[gv]];
        end
      end
      onoff_delay #(
        .DLY_W (DLY_W)
      ) u_dly (
        .mclk   (mclk),
        .rst_n  (rst_n),
        .tick   (tickEn),
        .rawIn  (dRaw[gv]),
        .setDly (dSetDly_q[gv]),
        .resDly (dResDly_q[gv]),
        .dlyOut (dDly[gv])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // virtual connections
  // ----------------------------------------------------------------
  logic [NSRC:0]       srcPad;
  logic [NUM_VC-1:0]   vcLevel;
  logic [NUM_FUNC-1:0] destVec;
  logic [NUM_FUNC-1:0] destPart [NUM_VC+1];

  // code 0 is off; code k picks source bit k-1
  assign srcPad = {digSignals, cmpOut.digital, cmpOut.analogInv, cmpOut.analogTrue, 1'b0};
  assign destPart[0] = '0;

  generate
    for (gv = 0; gv < NUM_VC; gv++) begin : g_vc
      assign vcLevel[gv] = (vconn_q[gv].src <= 8'(NSRC)) && srcPad[vconn_q[gv].src];
      assign destPart[gv+1] = destPart[gv] |
        ((vcLevel[gv] && vconn_q[gv].dest != 8'h00 && vconn_q[gv].dest <= 8'(NUM_FUNC)) ?
         (NUM_FUNC'(1) << (vconn_q[gv].dest - 8'h01)) : '0);
    end
  endgenerate

  assign destVec = destPart[NUM_VC];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      funcReq    <= '0;
      cmpOut     <= '{digital: '0, analogInv: '1, analogTrue: '0};
      updateTick <= 1'b0;
    end else begin
      updateTick <= tickEn;
      if (tickEn) begin
        funcReq <= physFuncReq | destVec;
      end
      cmpOut.analogTrue <= aDly;
      cmpOut.analogInv  <= ~aDly;
      cmpOut.digital    <= dDly;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rdVc;
  logic [31:0] rdAcfg;
  logic [31:0] rdStat;
  logic [31:0] rdData;
  logic [1:0]  rIdx4;

  assign rIdx4  = ra[3:2];
  assign rdVc   = {16'h0000, vconn_q[ra[4:2]].src, vconn_q[ra[4:2]].dest};
  assign rdAcfg = {27'h0, acmpCfg_q[rIdx4].mode, acmpCfg_q[rIdx4].sel};
  assign rdStat = {20'h00000, cmpOut.digital, cmpOut.analogInv, cmpOut.analogTrue};

  assign rdData = (ra[7:5] == VcOfs[7:5])     ? rdVc :
                  (ra[7:4] == AcfgOfs[7:4])   ? rdAcfg :
                  (ra[7:4] == AupOfs[7:4])    ? 32'(upper_q[rIdx4]) :
                  (ra[7:4] == AloOfs[7:4])    ? 32'(lower_q[rIdx4]) :
                  (ra[7:4] == AsetOfs[7:4])   ? 32'(aSetDly_q[rIdx4]) :
                  (ra[7:4] == AresOfs[7:4])   ? 32'(aResDly_q[rIdx4]) :
                  (ra[7:4] == DselOfs[7:4])   ? 32'(dSel_q[rIdx4]) :
                  (ra[7:4] == DsetOfs[7:4])   ? 32'(dSetDly_q[rIdx4]) :
                  (ra[7:4] == DresOfs[7:4])   ? 32'(dResDly_q[rIdx4]) :
                  (ra == StatOfs)             ? rdStat : 32'h00000000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= '0;
    end else if (accept && !hwrite) begin
      hrdata <= rdData;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_or_combine: assert property (@(posedge mclk) disable iff (!rst_n)
    tickEn |=> funcReq == ($past(physFuncReq) | $past(destVec)))
    else $error("function request is not the OR of its sources");

  a_func_on_tick: assert property (@(posedge mclk) disable iff (!rst_n)
    !tickEn |=> $stable(funcReq))
    else $error("function request changed between update ticks");

  a_tick_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    updateTick |=> !updateTick)
    else $error("update tick wider than one cycle");

  a_inv_compl: assert property (@(posedge mclk) disable iff (!rst_n)
    cmpOut.analogInv == ~cmpOut.analogTrue)
    else $error("inverted analogue output not the complement");

  a_vc_off_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    tickEn && destVec == '0 |=> funcReq == $past(physFuncReq))
    else $error("disabled connections still drive a function");

endmodule // virtual_io_and_comparators

// [design/vio_defines.svh]
`ifndef VIO_DEFINES_SVH
`define VIO_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets (VC_OFS starts eight aligned words, each comparator block four, STAT_OFS one)
// ----------------------------------------------------------------
`define VC_OFS        8'h00
`define ACFG_OFS      8'h40
`define AUP_OFS       8'h50
`define ALO_OFS       8'h60
`define ASET_OFS      8'h70
`define ARES_OFS      8'h80
`define DSEL_OFS      8'h90
`define DSET_OFS      8'ha0
`define DRES_OFS      8'hb0
`define STAT_OFS      8'hc0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define VC_DEST_LSB   0
`define VC_SRC_LSB    8
`define ACFG_SEL_LSB  0
`define ACFG_MODE_BIT 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define VC_OFF        8'h00
`define ACFG_SEL_RST  4'h4
`define AUP_RST       16'h012c
`define ALO_RST       16'h00c8
`define DSEL_RST      8'h01
`define DLY_RST       24'h000000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TICK_PERIOD_MS 8
`define CLK_FREQ_KHZ   100000
`define TICK_CYCLES    (`TICK_PERIOD_MS * `CLK_FREQ_KHZ)

`endif

// [design/vio_pkg.sv]
package vio_pkg;

  typedef enum logic [0:0] {
    HYSTERESIS = 1'b0,
    WINDOW     = 1'b1
  } cmpMode_type;

  typedef enum logic [3:0] {
    D_LOW  = 4'b0001,
    D_RISE = 4'b0010,
    D_HIGH = 4'b0100,
    D_FALL = 4'b1000
  } dlyState_type;

  typedef struct packed {
    cmpMode_type mode;
    logic [3:0]  sel;
  } acmpCfg_type;

  typedef struct packed {
    logic [7:0] src;
    logic [7:0] dest;
  } vconn_type;

  typedef struct packed {
    logic [3:0] digital;
    logic [3:0] analogInv;
    logic [3:0] analogTrue;
  } cmpOut_type;

endpackage

// [design/onoff_delay.sv]
`timescale 1ns/10ps
module onoff_delay
  import vio_pkg::*;
#(
  parameter int DLY_W = 24
) (
  input  logic             mclk,
  input  logic             rst_n,
  input  logic             tick,
  input  logic             rawIn,
  input  logic [DLY_W-1:0] setDly,
  input  logic [DLY_W-1:0] resDly,
  output logic             dlyOut
);

  dlyState_type     state_q;
  dlyState_type     state_d;
  logic [DLY_W-1:0] cnt_q;
  logic [DLY_W-1:0] cnt_d;
  logic [DLY_W-1:0] cntInc;

  assign cntInc = cnt_q + {{(DLY_W-1){1'b0}}, 1'b1};
  assign dlyOut = (state_q == D_HIGH) || (state_q == D_FALL);

  // ----------------------------------------------------------------
  // set and reset delays, counted in update ticks
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (tick) begin
      case (state_q)
        D_LOW: begin
          cnt_d = {{(DLY_W-1){1'b0}}, 1'b1};
          if (rawIn) begin
            state_d = (setDly == '0) ? D_HIGH : D_RISE;
          end
        end
        D_RISE: begin
          cnt_d = cntInc;
          if (!rawIn) begin
            state_d = D_LOW;
          end else if (cnt_q >= setDly) begin
            state_d = D_HIGH;
          end
        end
        D_HIGH: begin
          cnt_d = {{(DLY_W-1){1'b0}}, 1'b1};
          if (!rawIn) begin
            state_d = (resDly == '0) ? D_LOW : D_FALL;
          end
        end
        D_FALL: begin
          cnt_d = cntInc;
          if (rawIn) begin
            state_d = D_HIGH;
          end else if (cnt_q >= resDly) begin
            state_d = D_LOW;
          end
        end
        default: begin
          state_d = D_LOW;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= D_LOW;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  a_set_delay_end: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && state_q == D_RISE && rawIn && cnt_q >= setDly |=> dlyOut)
    else $error("set delay expired but output stayed low");

  a_reset_delay_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && state_q == D_FALL && !rawIn && cnt_q < resDly |=> dlyOut)
    else $error("output dropped before reset delay expired");

endmodule // onoff_delay

// [design/analog_cmp.sv]
`timescale 1ns/10ps
module analog_cmp
  import vio_pkg::*;
#(
  parameter int VAL_W = 16
) (
  input  logic             mclk,
  input  logic             rst_n,
  input  logic             tick,
  input  logic [VAL_W-1:0] value,
  input  logic [VAL_W-1:0] upper,
  input  logic [VAL_W-1:0] lower,
  input  cmpMode_type      mode,
  output logic             cmpRaw
);

  logic aboveUp;
  logic belowLo;
  logic latchMode;
  logic inBand;
  logic hystNext;

  assign aboveUp   = value > upper;
  assign belowLo   = value < lower;
  assign latchMode = lower > upper;
  assign inBand    = (value >= lower) && (value <= upper);
  // a crossed lower level only clears when the levels are in order
  assign hystNext  = aboveUp ? 1'b1 :
                     (belowLo && !latchMode) ? 1'b0 : cmpRaw;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmpRaw <= 1'b0;
    end else if (tick) begin
      cmpRaw <= (mode == WINDOW) ? inBand : hystNext;
    end
  end

  a_hyst_set: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && mode == HYSTERESIS && aboveUp |=> cmpRaw)
    else $error("hysteresis output not set above upper level");

  a_hyst_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && mode == HYSTERESIS && belowLo && !aboveUp && !latchMode |=> !cmpRaw)
    else $error("hysteresis output not cleared below lower level");

  a_hyst_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && mode == HYSTERESIS && !aboveUp && !belowLo |=> $stable(cmpRaw))
    else $error("hysteresis output changed between levels");

  a_latch_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && mode == HYSTERESIS && latchMode && cmpRaw |=> cmpRaw)
    else $error("latching comparator released");

  a_window_band: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && mode == WINDOW |=> cmpRaw == $past(inBand))
    else $error("window output does not follow band");

  a_tick_only: assert property (@(posedge mclk) disable iff (!rst_n)
    !tick |=> $stable(cmpRaw))
    else $error("comparator changed without update tick");

endmodule // analog_cmp

// [dv/vio_partner.sv]
`timescale 1ns/10ps
// ----------------------------------------
// measurement sources and physical inputs
// ----------------------------------------
module vio_partner (
  output logic [15:0][15:0] analogValues,
  output logic [115:0]      digSignals,
  output logic [63:0]       physFuncReq
);
  initial begin
    analogValues = '0;
    digSignals   = '0;
    physFuncReq  = '0;
  end
  // callers sit just after a rising edge, so these updates never race it
  task setA(input int i, input logic [15:0] v);
    analogValues[i] <= v;
  endtask
  task setD(input int i, input logic v);
    digSignals[i] <= v;
  endtask
  task setP(input logic [63:0] v);
    physFuncReq <= v;
  endtask
endmodule // vio_partner

// [dv/tb.sv]
`timescale 1ns/10ps
`include "vio_defines.svh"
module tb
  import vio_pkg::*;
;
  localparam int TICK = 20;
  logic              mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdPh = 1'b0;
  logic              hreadyout, hresp, updateTick;
  logic [31:0]       haddr = '0, hwdata = '0, hrdata;
  logic [1:0]        htrans = '0;
  logic [2:0]        hsize = 3'h2;
  logic [15:0][15:0] analogValues;
  logic [115:0]      digSignals;
  logic [63:0]       physFuncReq, funcReq, pv;
  cmpOut_type        cmpOut;
  logic [31:0]       expQ[$];
  logic [63:0]       fq[$];
  int                n_errors = 0, checks = 0, gap = 0;
  integer            seed = 32'hd555;
  logic [15:0]       hv[5] = '{16'h0032, 16'h0046, 16'h0032, 16'h001e, 16'h0032};
  logic              ht[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [15:0]       wv[5] = '{16'h0032, 16'h0028, 16'h0046, 16'h001e, 16'h003c};
  logic              wt[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  always #5 mclk = ~mclk;

  virtual_io_and_comparators #(.TICK_CYCLES(TICK)) DUT (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .analogValues(analogValues),
    .digSignals(digSignals), .physFuncReq(physFuncReq), .funcReq(funcReq),
    .cmpOut(cmpOut), .updateTick(updateTick));
  vio_partner P (.analogValues(analogValues), .digSignals(digSignals), .physFuncReq(physFuncReq));

  // ----------------------------------------
  // bus, tick and compare helpers
  // ----------------------------------------
  task cmp(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // the note is queued only after the address edge, so a stale data phase never takes it
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdPh <= 1'b0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    if (!w) expQ.push_back(d);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? d : 32'h0;
    rdPh <= ~w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask
  task ticks(input int n);
    repeat (n) do @(posedge mclk); while (updateTick !== 1'b1);
  endtask
  function logic [31:0] st(input logic t, input logic d);
    return {20'h0, 3'b000, d, 3'b111, ~t, 3'b000, t};
  endfunction
  task lvl(input logic [15:0] v, input logic t);
    P.setA(12, v);
    ticks(3);
    ahb(1'b0, `STAT_OFS, st(t, 1'b0));
  endtask
  task fchk(input logic [63:0] e);
    ticks(1);
    @(posedge mclk);
    fq.push_back(e);
    ticks(1);
  endtask
  task end_of_test();
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge mclk) begin
    if (rdPh === 1'b1 && expQ.size() > 0) cmp(hrdata, expQ.pop_front());
    if (updateTick === 1'b1 && fq.size() > 0) cmp(funcReq, fq.pop_front());
    if (updateTick === 1'b1) cmp(64'(cmpOut.analogInv ^ cmpOut.analogTrue), 64'hf);
    if (rdPh === 1'b1) cmp(64'(hresp), 64'h0);
    if (updateTick === 1'b1 && gap != 0) cmp(64'(gap), 64'(TICK));
    gap <= (updateTick === 1'b1) ? 1 : (gap != 0 ? gap + 1 : 0);
  end

  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) ahb(1'b0, `VC_OFS + 8'(4 * i), 32'h0);
    ahb(1'b0, `ACFG_OFS, 32'h4);
    ahb(1'b0, `DSEL_OFS, 32'h1);
    ahb(1'b0, `STAT_OFS, st(1'b0, 1'b0));
    ahb(1'b0, 8'hfc, 32'h0);
    ahb(1'b1, `STAT_OFS, 32'hfff);
    ahb(1'b0, `STAT_OFS, st(1'b0, 1'b0));
    ahb(1'b0, `AUP_OFS, 32'h12c);
    ahb(1'b1, `AUP_OFS, 32'h3c);
    ahb(1'b0, `AUP_OFS, 32'h3c);
    ahb(1'b1, `ALO_OFS, 32'h28);
    ahb(1'b1, `ACFG_OFS, 32'hc);
    for (int i = 0; i < 5; i++) lvl(hv[i], ht[i]);
    ahb(1'b1, `ALO_OFS, 32'h50);
    lvl(16'h0046, 1'b1);
    lvl(16'h000a, 1'b1);
    ahb(1'b1, `ALO_OFS, 32'h28);
    ahb(1'b1, `ACFG_OFS, 32'h1c);
    for (int i = 0; i < 5; i++) lvl(wv[i], wt[i]);
    ahb(1'b1, `ACFG_OFS, 32'hc);
    lvl(16'h000a, 1'b0);
    ahb(1'b1, `ASET_OFS, 32'h3);
    ahb(1'b1, `ARES_OFS, 32'h3);
    P.setA(12, 16'h0046);
    ticks(2);
    ahb(1'b0, `STAT_OFS, st(1'b0, 1'b0));
    ticks(6);
    ahb(1'b0, `STAT_OFS, st(1'b1, 1'b0));
    P.setA(12, 16'h000a);
    ticks(2);
    ahb(1'b0, `STAT_OFS, st(1'b1, 1'b0));
    ticks(6);
    ahb(1'b0, `STAT_OFS, st(1'b0, 1'b0));
    ahb(1'b1, `ASET_OFS, 32'h0);
    ahb(1'b1, `ARES_OFS, 32'h0);
    ahb(1'b1, `DSEL_OFS, 32'h2);
    P.setD(1, 1'b1);
    ticks(3);
    ahb(1'b0, `STAT_OFS, st(1'b0, 1'b1));
    pv = {$random(seed), $random(seed)};
    P.setP(pv);
    ahb(1'b1, `VC_OFS, 32'h0f05);
    ahb(1'b1, `VC_OFS + 8'h4, 32'h010a);
    P.setD(2, 1'b1);
    P.setA(12, 16'h0046);
    ticks(3);
    fchk(pv | 64'h210);
    pv = {$random(seed), $random(seed)};
    P.setP(pv);
    P.setD(2, 1'b0);
    P.setA(12, 16'h000a);
    ticks(3);
    fchk(pv);
    ticks(2);
    end_of_test();
  end
endmodule // tb
